// ===== core/pmic_top.v
// Per-port MAC ingress control: AXI4-Lite register bank plus per-frame admission and rate-tally logic.
// Functional notes
// - Storm bit enables broadcast storm protection.
// - Jumbo set accepts payload up to 9000.
// - Jumbo clear limits payload to 1500 bytes.
// - Back pressure only when enabled and half duplex.
// - Full duplex uses PAUSE, separate enable.
// - Bad frames dropped, or mirror-only with pass-all.
// - Pass-all never changes flow-control frame filtering.
// - Selector one per port, zero per priority.
// - PPS bit counts packets, else bytes.
// - Limit flow control bit asserts on overrun.
// - Needs port flow control enabled too.
// - Mode field selects counted frame classes.
// - IFG bit adds twelve bytes per frame.
// - Preamble bit adds eight bytes per frame.
// - Preamble bit ignored in packet mode.
// - Separate transmit and receive flow control bits.
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "pmic_map.vh"

module pmic_top (
  input  wire        aclk,               // Switch core clock.
  input  wire        aresetn,            // Synchronous reset, active low.
  // AXI4-Lite slave.
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Frame descriptor from the receive MAC, one pulse per frame.
  input  wire        frm_valid,
  input  wire [13:0] frm_payload_len,
  input  wire [15:0] frm_bytes,
  input  wire [1:0]  frm_prio,
  input  wire        frm_crc_err,
  input  wire        frm_runt,
  input  wire        frm_bcast,
  input  wire        frm_mcast,
  input  wire        frm_flood,
  input  wire        frm_is_ctrl,
  input  wire        ctrl_filter_en,     // Switch-level filtering of flow-control frames.
  input  wire        rate_exceeded,      // Limiter reports the receive rate is over budget.
  input  wire        collision_req,      // Buffer asks to hold off the partner.
  // Per-frame verdict, one pulse one cycle after frm_valid.
  output reg         verdict_valid,
  output reg         verdict_drop,
  output reg         verdict_mirror_only,
  output reg         verdict_oversize,
  output reg         verdict_counted,
  output reg  [15:0] verdict_tally,
  output reg  [1:0]  verdict_limit_class,
  // Steady controls toward the MAC and limiter.
  output reg         storm_protect_en,
  output reg         limit_per_port,
  output reg         limit_pps_mode,
  output reg         backpressure_active,
  output reg         pause_en,
  output reg         rx_pause_honour,
  output reg         rate_fc_assert
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [7:0]  feature_reg;        // Storm protection and jumbo enables.
  reg  [7:0]  duplex_filt_reg;    // Back pressure and pass-all.
  reg  [7:0]  limit_policy_reg;   // Ingress limiter policy.
  reg  [7:0]  port_flow_reg;      // Duplex and per-direction flow control.
  reg  [7:0]  drop_count_reg;     // Saturating count of dropped frames.
  reg  [7:0]  mirror_count_reg;   // Saturating count of mirror-only frames.

  // Write channel holding registers; address and data may arrive in either order.
  reg  [15:0] wr_addr_reg;
  reg         wr_addr_ok_reg;
  reg  [7:0]  wr_data_reg;
  reg         wr_strb_reg;
  reg         wr_data_ok_reg;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Maps a byte address onto a register index; misaligned or out-of-range gives an index that never matches.
  function [11:0] addr_index;
    input [15:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[15:14] != 2'h0) begin
        addr_index = 12'hfff;
      end else begin
        addr_index = addr[13:2];
      end
    end
  endfunction

  // Tells whether an index names a register of this block.
  function mapped;
    input [11:0] idx;
    begin
      mapped = (idx == `PMIC_IDX_FEATURE) || (idx == `PMIC_IDX_DUPLEX_FILT) ||
               (idx == `PMIC_IDX_LIMIT_POLICY) || (idx == `PMIC_IDX_PORT_FLOW) ||
               (idx == `PMIC_IDX_STATUS);
    end
  endfunction

  // Read-back value of a register; reserved bits read as zero.
  function [7:0] read_value;
    input [11:0] idx;
    begin
      case (idx)
        `PMIC_IDX_FEATURE:      read_value = feature_reg;
        `PMIC_IDX_DUPLEX_FILT:  read_value = duplex_filt_reg;
        `PMIC_IDX_LIMIT_POLICY: read_value = limit_policy_reg;
        `PMIC_IDX_PORT_FLOW:    read_value = port_flow_reg;
        `PMIC_IDX_STATUS:       read_value = drop_count_reg;
        default:                read_value = 8'h00;
      endcase
    end
  endfunction

  // Saturating increment for the event counters.
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      sat_inc = (v == 8'hff) ? v : v + 8'h01;
    end
  endfunction

  // ****************************************************************
  // Field decode.
  // ****************************************************************
  wire       jumbo_en   = feature_reg[`PMIC_FEAT_JUMBO];
  wire       pass_all   = duplex_filt_reg[`PMIC_DUPF_PASS_ALL];
  wire       bp_en      = duplex_filt_reg[`PMIC_DUPF_BACKPRESS];
  wire       lim_pre    = limit_policy_reg[`PMIC_LIM_PREAMBLE];
  wire       lim_ifg    = limit_policy_reg[`PMIC_LIM_IFG];
  wire [1:0] lim_mode   = limit_policy_reg[`PMIC_LIM_MODE_HI:`PMIC_LIM_MODE_LO];
  wire       lim_fc     = limit_policy_reg[`PMIC_LIM_FC];
  wire       lim_pps    = limit_policy_reg[`PMIC_LIM_PPS];
  wire       lim_port   = limit_policy_reg[`PMIC_LIM_PER_PORT];
  wire       tx_fc_en   = port_flow_reg[`PMIC_FLOW_TX_FC];
  wire       rx_fc_en   = port_flow_reg[`PMIC_FLOW_RX_FC];
  wire       full_dup   = port_flow_reg[`PMIC_FLOW_DUPLEX];

  // ****************************************************************
  // Frame classification.
  // ****************************************************************
  reg        oversize_c;      // Payload over the active ceiling.
  reg        bad_c;           // CRC error, oversize or runt.
  reg        counted_c;       // Frame falls in the limited class.
  reg [15:0] tally_c;         // Amount charged to the limiter.

  // Combinational verdict for the frame on the descriptor inputs.
  always @* begin
    // The ceiling moves with the jumbo bit; longer frames count as bad.
    if (jumbo_en) begin
      oversize_c = frm_payload_len > `PMIC_PAYLOAD_JUMBO;
    end else begin
      oversize_c = frm_payload_len > `PMIC_PAYLOAD_STD;
    end
    bad_c = frm_crc_err | frm_runt | oversize_c;
    // Pick the frame classes that the limiter charges.
    case (lim_mode)
      `PMIC_MODE_ALL:         counted_c = 1'b1;
      `PMIC_MODE_BC_MC_FLOOD: counted_c = frm_bcast | frm_mcast | frm_flood;
      `PMIC_MODE_BC_MC:       counted_c = frm_bcast | frm_mcast;
      `PMIC_MODE_BC:          counted_c = frm_bcast;
      default:                counted_c = 1'b1;
    endcase
    // Packet mode charges one unit and ignores the byte extras.
    if (lim_pps) begin
      tally_c = `PMIC_ONE_PACKET;
    end else begin
      tally_c = frm_bytes;
      if (lim_ifg) begin
        tally_c = tally_c + `PMIC_IFG_BYTES;
      end
      if (lim_pre) begin
        tally_c = tally_c + `PMIC_PREAMBLE_BYTES;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite write path.
  // ****************************************************************
  wire [11:0] wr_idx   = addr_index(wr_addr_reg);
  wire        wr_fire  = wr_addr_ok_reg & wr_data_ok_reg & ~s_axi_bvalid;
  wire        wr_take  = wr_fire & wr_strb_reg;

  // Accepts address and data independently, then commits once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `PMIC_RESP_OKAY;
      wr_addr_reg      <= 16'h0000;
      wr_addr_ok_reg   <= 1'b0;
      wr_data_reg      <= 8'h00;
      wr_strb_reg      <= 1'b0;
      wr_data_ok_reg   <= 1'b0;
      feature_reg      <= `PMIC_REG_RESET;
      duplex_filt_reg  <= `PMIC_REG_RESET;
      limit_policy_reg <= `PMIC_REG_RESET;
      port_flow_reg    <= `PMIC_REG_RESET;
    end else begin
      // Ready is offered for one cycle while the slot is empty.
      s_axi_awready <= ~wr_addr_ok_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wr_data_ok_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        wr_addr_reg    <= s_axi_awaddr;
        wr_addr_ok_reg <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wr_data_reg    <= s_axi_wdata[7:0];
        wr_strb_reg    <= s_axi_wstrb[0];
        wr_data_ok_reg <= 1'b1;
      end
      if (wr_fire) begin
        wr_addr_ok_reg <= 1'b0;
        wr_data_ok_reg <= 1'b0;
        s_axi_bvalid   <= 1'b1;
        s_axi_bresp    <= mapped(wr_idx) ? `PMIC_RESP_OKAY : `PMIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid   <= 1'b0;
      end
      // Only the writable bits change; reserved read-only bits stay zero.
      if (wr_take && wr_idx == `PMIC_IDX_FEATURE) begin
        feature_reg <= wr_data_reg & `PMIC_FEAT_WMASK;
      end
      if (wr_take && wr_idx == `PMIC_IDX_DUPLEX_FILT) begin
        duplex_filt_reg <= wr_data_reg & `PMIC_DUPF_WMASK;
      end
      if (wr_take && wr_idx == `PMIC_IDX_LIMIT_POLICY) begin
        limit_policy_reg <= wr_data_reg & `PMIC_LIM_WMASK;
      end
      if (wr_take && wr_idx == `PMIC_IDX_PORT_FLOW) begin
        port_flow_reg <= wr_data_reg & `PMIC_FLOW_WMASK;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path.
  // ****************************************************************
  wire [11:0] rd_idx = addr_index(s_axi_araddr);

  // One read at a time; the data comes the cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PMIC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, read_value(rd_idx)};
        s_axi_rresp  <= mapped(rd_idx) ? `PMIC_RESP_OKAY : `PMIC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Per-frame verdict.
  // ****************************************************************
  // Registers the verdict so every output leaves from a flop, one cycle after the descriptor.
  always @(posedge aclk) begin
    if (!aresetn) begin
      verdict_valid       <= 1'b0;
      verdict_drop        <= 1'b0;
      verdict_mirror_only <= 1'b0;
      verdict_oversize    <= 1'b0;
      verdict_counted     <= 1'b0;
      verdict_tally       <= 16'h0000;
      verdict_limit_class <= 2'h0;
      drop_count_reg      <= 8'h00;
      mirror_count_reg    <= 8'h00;
    end else begin
      verdict_valid <= frm_valid;
      if (frm_valid) begin
        verdict_oversize <= oversize_c;
        verdict_counted  <= counted_c;
        verdict_tally    <= counted_c ? tally_c : 16'h0000;
        // A single port bucket uses class zero; otherwise the frame priority picks it.
        verdict_limit_class <= lim_port ? 2'h0 : frm_prio;
        if (frm_is_ctrl) begin
          // Control frames follow the switch-level filter and are dropped when bad, whatever pass-all says.
          verdict_drop        <= ctrl_filter_en | bad_c;
          verdict_mirror_only <= 1'b0;
          if (ctrl_filter_en | bad_c) begin
            drop_count_reg <= sat_inc(drop_count_reg);
          end
        end else if (bad_c) begin
          // Bad frames die here unless pass-all sends them to the mirror port alone.
          verdict_drop        <= ~pass_all;
          verdict_mirror_only <= pass_all;
          if (pass_all) begin
            mirror_count_reg <= sat_inc(mirror_count_reg);
          end else begin
            drop_count_reg <= sat_inc(drop_count_reg);
          end
        end else begin
          verdict_drop        <= 1'b0;
          verdict_mirror_only <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Steady controls toward MAC and limiter.
  // ****************************************************************
  // Registered copies of the policy bits; the one-cycle lag after a write is harmless to traffic.
  always @(posedge aclk) begin
    if (!aresetn) begin
      storm_protect_en    <= 1'b0;
      limit_per_port      <= 1'b0;
      limit_pps_mode      <= 1'b0;
      backpressure_active <= 1'b0;
      pause_en            <= 1'b0;
      rx_pause_honour     <= 1'b0;
      rate_fc_assert      <= 1'b0;
    end else begin
      storm_protect_en    <= feature_reg[`PMIC_FEAT_STORM];
      limit_per_port      <= lim_port;
      limit_pps_mode      <= lim_pps;
      // Jamming by collision only makes sense on a shared medium.
      backpressure_active <= bp_en & ~full_dup & collision_req;
      // Full duplex throttles with PAUSE frames under the port's own enables.
      pause_en            <= full_dup & tx_fc_en;
      rx_pause_honour     <= full_dup & rx_fc_en;
      // Overrun raises flow control only when the port also permits it.
      rate_fc_assert      <= lim_fc & rate_exceeded & tx_fc_en;
    end
  end

endmodule

// ===== inc/pmic_map.vh
// Register map, field positions, reset values and frame limits of the port MAC ingress control block.
`ifndef PMIC_MAP_VH
`define PMIC_MAP_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define PMIC_IDX_FEATURE      12'h400
`define PMIC_IDX_DUPLEX_FILT  12'h401
`define PMIC_IDX_LIMIT_POLICY 12'h403
`define PMIC_IDX_PORT_FLOW    12'h404
`define PMIC_IDX_STATUS       12'h405

// ****************************************************************
// Field positions.
// ****************************************************************
`define PMIC_FEAT_JUMBO       0
`define PMIC_FEAT_STORM       1
`define PMIC_DUPF_PASS_ALL    0
`define PMIC_DUPF_BACKPRESS   3
`define PMIC_LIM_PREAMBLE     0
`define PMIC_LIM_IFG          1
`define PMIC_LIM_MODE_LO      2
`define PMIC_LIM_MODE_HI      3
`define PMIC_LIM_FC           4
`define PMIC_LIM_PPS          5
`define PMIC_LIM_PER_PORT     6
`define PMIC_FLOW_RX_FC       3
`define PMIC_FLOW_TX_FC       5
`define PMIC_FLOW_DUPLEX      6

// ****************************************************************
// Writable-bit masks and reset values.
// ****************************************************************
`define PMIC_FEAT_WMASK       8'h0b
`define PMIC_DUPF_WMASK       8'hbf
`define PMIC_LIM_WMASK        8'h7f
`define PMIC_FLOW_WMASK       8'h68
`define PMIC_REG_RESET        8'h00

// ****************************************************************
// Limit mode encodings.
// ****************************************************************
`define PMIC_MODE_ALL         2'h0
`define PMIC_MODE_BC_MC_FLOOD 2'h1
`define PMIC_MODE_BC_MC       2'h2
`define PMIC_MODE_BC          2'h3

// ****************************************************************
// Frame sizes in bytes, and the one-packet tally of packet mode.
// ****************************************************************
`define PMIC_PAYLOAD_STD      14'h05dc
`define PMIC_PAYLOAD_JUMBO    14'h2328
`define PMIC_IFG_BYTES        16'h000c
`define PMIC_PREAMBLE_BYTES   16'h0008
`define PMIC_ONE_PACKET       16'h0001

// ****************************************************************
// AXI responses.
// ****************************************************************
`define PMIC_RESP_OKAY        2'h0
`define PMIC_RESP_SLVERR      2'h2

`endif

// ===== tb/pmic_checker_assertions.sv
// Concurrent checks on the port MAC ingress control ports.
module pmic_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire        frm_valid,
  input wire [13:0] frm_payload_len,
  input wire        frm_is_ctrl,
  input wire        collision_req,
  input wire        rate_exceeded,
  input wire        verdict_valid,
  input wire        verdict_drop,
  input wire        verdict_mirror_only,
  input wire        verdict_oversize,
  input wire        verdict_counted,
  input wire [15:0] verdict_tally,
  input wire [1:0]  verdict_limit_class,
  input wire        limit_per_port,
  input wire        limit_pps_mode,
  input wire        backpressure_active,
  input wire        pause_en,
  input wire        rate_fc_assert
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Properties, all in the core clock domain.
  // ****************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Every descriptor gets exactly one verdict pulse, one cycle later.
  a_verdict_pulse: assert property (frm_valid |=> verdict_valid)
    else $error("verdict missing after frame");
  a_verdict_quiet: assert property (!frm_valid |=> !verdict_valid)
    else $error("verdict without frame");
  // A payload above the jumbo ceiling is oversize whatever the setting.
  a_oversize_bad: assert property (frm_valid && frm_payload_len > 14'h2328
    |=> verdict_oversize && (verdict_drop || verdict_mirror_only)) else $error("oversize frame passed");
  a_ctrl_no_mirror: assert property (frm_valid && frm_is_ctrl |=> !verdict_mirror_only)
    else $error("control frame sent to mirror");
  a_pps_tally: assert property (verdict_valid && verdict_counted && limit_pps_mode
    |-> verdict_tally == 16'h0001) else $error("packet mode tally not one");
  a_uncounted_zero: assert property (verdict_valid && !verdict_counted
    |-> verdict_tally == 16'h0000) else $error("uncounted frame has tally");
  a_port_class: assert property (verdict_valid && limit_per_port
    |-> verdict_limit_class == 2'h0) else $error("per port class not zero");
  // Back pressure needs a request and excludes full duplex pause.
  a_bp_cause: assert property (backpressure_active |-> $past(collision_req) && !pause_en)
    else $error("back pressure without cause");
  a_rate_fc_cause: assert property (rate_fc_assert |-> $past(rate_exceeded))
    else $error("rate flow control without overrun");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");

  c_mirror: cover property (verdict_valid && verdict_mirror_only);
  c_bp: cover property (backpressure_active);
  c_rate_fc: cover property (rate_fc_assert);
endmodule

bind pmic_top pmic_checker u_chk (.*);

// ===== tb/pmic_frame_src.sv
// Receive MAC model that hands one frame descriptor to the block.
module pmic_frame_src (
  input  wire        aclk,
  input  wire        go,
  input  wire [13:0] len,
  input  wire [15:0] bytes,
  input  wire [5:0]  fl,
  output reg         frm_valid,
  output reg  [13:0] frm_payload_len,
  output reg  [15:0] frm_bytes,
  output reg  [1:0]  frm_prio,
  output reg         frm_crc_err,
  output reg         frm_runt,
  output reg         frm_bcast,
  output reg         frm_mcast,
  output reg         frm_flood,
  output reg         frm_is_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle descriptor; outside it the fields toggle so no stale value looks valid.
  always @(posedge aclk) begin
    frm_valid <= go;
    if (go) begin
      {frm_payload_len, frm_bytes, frm_prio} <= {len, bytes, 2'h2};
      {frm_crc_err, frm_runt, frm_bcast, frm_mcast, frm_flood, frm_is_ctrl} <= fl;
    end else begin
      {frm_payload_len, frm_bytes, frm_prio} <= ~{frm_payload_len, frm_bytes, frm_prio};
      {frm_crc_err, frm_runt, frm_bcast, frm_mcast, frm_flood, frm_is_ctrl} <=
        ~{frm_crc_err, frm_runt, frm_bcast, frm_mcast, frm_flood, frm_is_ctrl};
    end
  end
endmodule

// ===== tb/port_mac_ingress_control_tb.sv
// Self-checking bench for the port MAC ingress control block.
module port_mac_ingress_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [13:0] len;
    logic [7:0]  feat;
    logic [7:0]  dupf;
    logic [7:0]  pol;
    logic [5:0]  fl;
    logic [3:0]  ex;   // Drop, mirror only, oversize, counted.
    logic [15:0] tal;
  } pmic_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, collision_req = 1'b0, rate_exceeded = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000, bytes = 16'h0040;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ctrl_filter_en = 1'b0;
  logic [13:0] len = 14'h0040;
  logic [5:0]  fl = 6'h00;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, frm_prio, verdict_limit_class;
  wire  [31:0] s_axi_rdata;
  wire  [13:0] frm_payload_len;
  wire  [15:0] frm_bytes, verdict_tally;
  wire         frm_valid, frm_crc_err, frm_runt, frm_bcast, frm_mcast, frm_flood, frm_is_ctrl;
  wire         verdict_valid, verdict_drop, verdict_mirror_only, verdict_oversize, verdict_counted;
  wire         storm_protect_en, limit_per_port, limit_pps_mode, backpressure_active;
  wire         pause_en, rx_pause_honour, rate_fc_assert;
  int          num_errors = 0, n_compared = 0, i;
  pmic_row_t   rows [19];
  pmic_row_t   r;
  logic [15:0] ad [4] = '{16'h1000, 16'h1004, 16'h100c, 16'h1010};
  logic [7:0]  mk [4] = '{8'h0b, 8'hbf, 8'h7f, 8'h68};

  always #10 aclk = ~aclk;

  pmic_top DUT (.*, .s_axi_wstrb(4'h1));
  pmic_frame_src u_src (.*);

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    $display("[ERR] %0t wait limit reached", $time);
    conclude();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken.
  task automatic axw(input logic [15:0] a, input logic [7:0] d, output logic [1:0] rr);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
    if (k == 40) tmo();
  endtask
  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rr);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
    if (k == 40) tmo();
  endtask
  // Frame: the model pulses the descriptor, then we catch the verdict pulse.
  task automatic frame(input logic [13:0] l, input logic [5:0] f);
    int k;
    @(posedge aclk);
    len <= l;
    fl <= f;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(posedge aclk);
      if (verdict_valid === 1'b1) break;
    end
    if (k == 8) tmo();
  endtask
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ****************************************************************
  // Main sequence: table rows first, then hand-written cases.
  // ****************************************************************
  initial begin
    rows = '{'{14'h05dc, 8'h00, 8'h00, 8'h00, 6'h00, 4'h1, 16'h0040},
             '{14'h05dd, 8'h00, 8'h00, 8'h00, 6'h00, 4'hb, 16'h0040},
             '{14'h05dd, 8'h01, 8'h00, 8'h00, 6'h00, 4'h1, 16'h0040},
             '{14'h2328, 8'h03, 8'h00, 8'h00, 6'h00, 4'h1, 16'h0040},
             '{14'h2329, 8'h01, 8'h00, 8'h00, 6'h00, 4'hb, 16'h0040},
             '{14'h0040, 8'h00, 8'h01, 8'h00, 6'h20, 4'h5, 16'h0040},
             '{14'h0040, 8'h00, 8'h00, 8'h00, 6'h10, 4'h9, 16'h0040},
             '{14'h0040, 8'h00, 8'h01, 8'h00, 6'h21, 4'h9, 16'h0040},
             '{14'h0040, 8'h00, 8'h00, 8'h02, 6'h00, 4'h1, 16'h004c},
             '{14'h0040, 8'h00, 8'h00, 8'h01, 6'h00, 4'h1, 16'h0048},
             '{14'h0040, 8'h00, 8'h00, 8'h03, 6'h00, 4'h1, 16'h0054},
             '{14'h0040, 8'h00, 8'h00, 8'h21, 6'h00, 4'h1, 16'h0001},
             '{14'h0040, 8'h00, 8'h00, 8'h04, 6'h02, 4'h1, 16'h0040},
             '{14'h0040, 8'h00, 8'h00, 8'h04, 6'h00, 4'h0, 16'h0000},
             '{14'h0040, 8'h00, 8'h00, 8'h08, 6'h04, 4'h1, 16'h0040},
             '{14'h0040, 8'h00, 8'h00, 8'h08, 6'h02, 4'h0, 16'h0000},
             '{14'h0040, 8'h00, 8'h00, 8'h0c, 6'h08, 4'h1, 16'h0040},
             '{14'h0040, 8'h00, 8'h00, 8'h0c, 6'h04, 4'h0, 16'h0000},
             '{14'h0040, 8'h00, 8'h00, 8'h40, 6'h00, 4'h1, 16'h0040}};
    rst();
    for (i = 0; i < 19; i++) begin
      r = rows[i];
      axw(16'h1000, r.feat, rs);
      axw(16'h1004, r.dupf, rs);
      axw(16'h100c, r.pol, rs);
      frame(r.len, r.fl);
      chk({verdict_drop, verdict_mirror_only, verdict_oversize, verdict_counted}, r.ex);
      chk(verdict_tally, r.tal);
      chk(verdict_limit_class, r.pol[6] ? 2'h0 : 2'h2);
      chk({storm_protect_en, limit_per_port, limit_pps_mode}, {r.feat[1], r.pol[6], r.pol[5]});
      $display("row %0d done", i);
    end
    // Four rows dropped a frame, so the status counter holds four.
    axr(16'h1014, rd, rs);
    chk(rd, 32'h4);
    // A good control frame follows the switch-level filter even with pass-all set.
    ctrl_filter_en <= 1'b1;
    axw(16'h1004, 8'h01, rs);
    frame(14'h0040, 6'h01);
    chk({verdict_drop, verdict_mirror_only}, 2'h2);
    ctrl_filter_en <= 1'b0;
    $display("control test done");
    // Reserved bits are masked on write and read back as zero.
    for (i = 0; i < 4; i++) begin
      axw(ad[i], 8'hff, rs);
      chk(rs, 2'h0);
      axr(ad[i], rd, rs);
      chk(rd, {24'h000000, mk[i]});
    end
    $display("mask test done");
    // Flow control: full duplex pauses without back pressure, then half duplex jams on collision.
    collision_req <= 1'b1;
    rate_exceeded <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({backpressure_active, pause_en, rx_pause_honour, rate_fc_assert}, 4'h7);
    axw(16'h1010, 8'h48, rs);
    repeat (3) @(posedge aclk);
    chk({backpressure_active, pause_en, rx_pause_honour, rate_fc_assert}, 4'h2);
    axw(16'h1010, 8'h00, rs);
    repeat (3) @(posedge aclk);
    chk({backpressure_active, pause_en, rx_pause_honour, rate_fc_assert}, 4'h8);
    axw(16'h1004, 8'h00, rs);
    repeat (3) @(posedge aclk);
    chk(backpressure_active, 1'b0);
    $display("flow control test done");
    // Unmapped and misaligned places answer with an error and read zero.
    axw(16'h1008, 8'h55, rs);
    chk(rs, 2'h2);
    axr(16'h1008, rd, rs);
    chk({rd, rs}, {32'h0, 2'h2});
    axr(16'h1001, rd, rs);
    chk(rs, 2'h2);
    $display("unmapped test done");
    // A second reset clears every register.
    rst();
    for (i = 0; i < 4; i++) begin
      axr(ad[i], rd, rs);
      chk(rd, 32'h0);
    end
    $display("reset test done");
    conclude();
  end
endmodule
